//--- design/board_glue.sv
// Board glue: memory and I/O decode, ROM wait insertion, bank and ROM-disable port bits,
// baud factor byte steering and fixed interrupt vector map.
// Assumes bus strobes are synchronous to ref_clk_i; supply_low_line_i is an async pin.
//
// Summary of operation
// - ROM from zero, size by type, waits
// - RAM at 3000, or 2000 when expanded
// - RAM window movable to any 16K top
// - Bank bit reaches 128K off-board memory
// - ROM enable low frees ROM range off-board
// - Baud factor loads as two byte writes
// - Controller register picked by order, data bit
// - Direct interrupts vector 24, 3C, 34, 2C
// - Low-line may be routed as trap
// - Timers DC-DD, control DF, two-byte counts
`timescale 1ns/1ps
module board_glue (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire board_glue_pkg::config_s cfg_i,
  input wire logic mem_cycle_i,
  input wire logic io_cycle_i,
  input wire logic wr_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0] data_i,
  input wire logic trap_i,
  input wire logic rst75_i,
  input wire logic rst65_i,
  input wire logic rst55_i,
  input wire logic supply_low_line_i,
  input wire logic bank_port_wr_i,
  output board_glue_pkg::select_s sel_o,
  output logic offboard_o,
  output logic ready_o,
  output logic bank_o,
  output logic onboard_rom_enable_o,
  output logic [15:0] baud_rate_factor_o,
  output logic [1:0] timer_byte_o,
  output logic pic_second_reg_o,
  output logic irq_pending_o,
  output logic [7:0] irq_vector_o
);
  board_glue_pkg::select_s sel_ff, nxt_sel;
  logic offboard_ff, nxt_offboard;
  logic ready_ff, nxt_ready;
  logic [1:0] wait_ff, nxt_wait;
  logic bank_ff, nxt_bank;
  logic rom_en_ff, nxt_rom_en;
  logic [15:0] baud_ff, nxt_baud;
  logic baud_hi_ff, nxt_baud_hi;
  logic [2:0] tmr_hi_ff, nxt_tmr_hi;
  logic [1:0] tmr_byte_ff, nxt_tmr_byte;
  logic [1:0] pic_seq_ff, nxt_pic_seq;
  logic pic_sel2_ff, nxt_pic_sel2;
  logic pend_ff, nxt_pend;
  logic [7:0] vec_ff, nxt_vec;
  logic low_line;
  logic [15:0] rom_top;
  logic rom_slow, rom_hit, ram_hit, io_baud, io_tmr, io_pic;
  logic cycle_start, mem_d_ff, io_d_ff;

  pin_sync u_low_line (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .pin_i(supply_low_line_i),
    .level_o(low_line)
  );

  // Region decode
  always_comb begin
    case (cfg_i.rom_type)
      board_glue_pkg::rom_1k_slow: rom_top = board_glue_pkg::rom_top_1k;
      board_glue_pkg::rom_2k_slow: rom_top = board_glue_pkg::rom_top_2k;
      board_glue_pkg::rom_4k_slow: rom_top = board_glue_pkg::rom_top_4k;
      board_glue_pkg::rom_4k_fast: rom_top = board_glue_pkg::rom_top_4k;
      board_glue_pkg::rom_8k_fast: rom_top = board_glue_pkg::rom_top_8k;
      default: rom_top = board_glue_pkg::rom_top_1k;
    endcase
    rom_slow = (cfg_i.rom_type == board_glue_pkg::rom_1k_slow) ||
               (cfg_i.rom_type == board_glue_pkg::rom_2k_slow) ||
               (cfg_i.rom_type == board_glue_pkg::rom_4k_slow);
    rom_hit = mem_cycle_i && (addr_i <= rom_top) &&
              !(cfg_i.rom_disable_allow && !rom_en_ff) &&
              !(cfg_i.bank_enable && cfg_i.bank_rom_follow && bank_ff);
    ram_hit = mem_cycle_i && !rom_hit && (addr_i[15:14] == cfg_i.ram_segment) &&
              ((addr_i[13:12] == board_glue_pkg::ram_small_lo) ||
               (cfg_i.ram_expanded && addr_i[13:12] == board_glue_pkg::ram_big_lo));
    io_baud = io_cycle_i && addr_i[7:0] == board_glue_pkg::baud_rate_factor_offset;
    io_tmr = io_cycle_i && !io_baud &&
             (addr_i[7:0] == board_glue_pkg::timer0_port ||
              addr_i[7:0] == board_glue_pkg::timer1_port ||
              addr_i[7:0] == board_glue_pkg::timer_ctrl_port);
    io_pic = io_cycle_i && addr_i[7:1] == board_glue_pkg::pic_port_base;
  end

  assign cycle_start = (mem_cycle_i && !mem_d_ff) || (io_cycle_i && !io_d_ff);

  always_comb begin
    nxt_sel.rom = rom_hit;
    nxt_sel.ram = ram_hit;
    nxt_sel.baud = io_baud;
    nxt_sel.timer = io_tmr;
    nxt_sel.pic = io_pic && !io_baud && !io_tmr;
    nxt_offboard = (mem_cycle_i || io_cycle_i) && !rom_hit && !ram_hit &&
                   !io_baud && !io_tmr && !io_pic;
    nxt_wait = wait_ff;
    nxt_ready = 1'b1;
    if (cycle_start && rom_hit && rom_slow) begin
      nxt_wait = board_glue_pkg::rom_wait_cycles;
      nxt_ready = 1'b0;
    end else if (wait_ff != 2'h0) begin
      nxt_wait = wait_ff - 2'h1;
      nxt_ready = (wait_ff == 2'h1);
    end
    if (cycle_start && rom_hit && rom_slow) begin
      nxt_ready = 1'b0;
    end else if (wait_ff > 2'h1) begin
      nxt_ready = 1'b0;
    end
  end

  // Port bits and byte steering
  always_comb begin
    nxt_bank = bank_ff;
    nxt_rom_en = rom_en_ff;
    nxt_baud = baud_ff;
    nxt_baud_hi = baud_hi_ff;
    nxt_tmr_hi = tmr_hi_ff;
    nxt_tmr_byte = 2'h0;
    nxt_pic_seq = pic_seq_ff;
    nxt_pic_sel2 = pic_sel2_ff;
    if (bank_port_wr_i) begin
      nxt_bank = cfg_i.bank_enable && data_i[0];
      nxt_rom_en = data_i[1];
    end
    if (io_cycle_i && !io_d_ff && wr_i) begin
      if (io_baud) begin
        if (baud_hi_ff) begin
          nxt_baud = {data_i, baud_ff[7:0]};
        end else begin
          nxt_baud = {baud_ff[15:8], data_i};
        end
        nxt_baud_hi = !baud_hi_ff;
      end
      if (io_tmr) begin
        case (addr_i[1:0])
          2'h0: begin
            nxt_tmr_byte = {tmr_hi_ff[0], 1'b1};
            nxt_tmr_hi[0] = !tmr_hi_ff[0];
          end
          2'h1: begin
            nxt_tmr_byte = {tmr_hi_ff[1], 1'b1};
            nxt_tmr_hi[1] = !tmr_hi_ff[1];
          end
          default: nxt_tmr_hi = 3'h0;
        endcase
      end
      if (io_pic) begin
        if (!addr_i[0] && data_i[4]) begin
          nxt_pic_seq = 2'h1;
          nxt_pic_sel2 = 1'b1;
        end else if (addr_i[0] && pic_seq_ff != 2'h0) begin
          nxt_pic_seq = pic_seq_ff - 2'h1;
          nxt_pic_sel2 = (pic_seq_ff != 2'h1);
        end else begin
          nxt_pic_sel2 = 1'b0;
        end
      end
    end
  end

  // Direct interrupt vector map
  always_comb begin
    nxt_pend = 1'b1;
    if (trap_i || (cfg_i.low_line_route && low_line)) begin
      nxt_vec = board_glue_pkg::vec_nmi;
    end else if (rst75_i) begin
      nxt_vec = board_glue_pkg::vec_hi;
    end else if (rst65_i) begin
      nxt_vec = board_glue_pkg::vec_mid;
    end else if (rst55_i) begin
      nxt_vec = board_glue_pkg::vec_lo;
    end else begin
      nxt_vec = 8'h00;
      nxt_pend = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      sel_ff <= '0;
      offboard_ff <= 1'b0;
      ready_ff <= 1'b1;
      wait_ff <= 2'h0;
      bank_ff <= 1'b0;
      rom_en_ff <= 1'b1;
      baud_ff <= board_glue_pkg::baud_reset;
      baud_hi_ff <= 1'b0;
      tmr_hi_ff <= 3'h0;
      tmr_byte_ff <= 2'h0;
      pic_seq_ff <= 2'h0;
      pic_sel2_ff <= 1'b0;
      pend_ff <= 1'b0;
      vec_ff <= 8'h00;
      mem_d_ff <= 1'b0;
      io_d_ff <= 1'b0;
    end else begin
      sel_ff <= nxt_sel;
      offboard_ff <= nxt_offboard;
      ready_ff <= nxt_ready;
      wait_ff <= nxt_wait;
      bank_ff <= nxt_bank;
      rom_en_ff <= nxt_rom_en;
      baud_ff <= nxt_baud;
      baud_hi_ff <= nxt_baud_hi;
      tmr_hi_ff <= nxt_tmr_hi;
      tmr_byte_ff <= nxt_tmr_byte;
      pic_seq_ff <= nxt_pic_seq;
      pic_sel2_ff <= nxt_pic_sel2;
      pend_ff <= nxt_pend;
      vec_ff <= nxt_vec;
      mem_d_ff <= mem_cycle_i;
      io_d_ff <= io_cycle_i;
    end
  end

  assign sel_o = sel_ff;
  assign offboard_o = offboard_ff;
  assign ready_o = ready_ff;
  assign bank_o = bank_ff;
  assign onboard_rom_enable_o = rom_en_ff;
  assign baud_rate_factor_o = baud_ff;
  assign timer_byte_o = tmr_byte_ff;
  assign pic_second_reg_o = pic_sel2_ff;
  assign irq_pending_o = pend_ff;
  assign irq_vector_o = vec_ff;

  AST_ONE_SELECT: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    $onehot0({sel_ff.rom, sel_ff.ram, sel_ff.baud, sel_ff.timer, sel_ff.pic, offboard_ff}))
    else $error("more than one select");
  AST_ROM_WAIT: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (cycle_start && rom_hit && rom_slow) |=> !ready_o ##1 ready_o)
    else $error("slow rom wait wrong");
  AST_ROM_FAST: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (cycle_start && rom_hit && !rom_slow && wait_ff == 2'h0) |=> ready_o)
    else $error("fast rom waited");
  AST_RAM_MAP: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (mem_cycle_i && !rom_hit && addr_i[15:14] == cfg_i.ram_segment &&
     addr_i[13:12] == board_glue_pkg::ram_small_lo) |=> sel_o.ram)
    else $error("ram not selected");
  AST_ROM_OFF: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (cfg_i.rom_disable_allow && !onboard_rom_enable_o) |=> !sel_o.rom)
    else $error("rom selected while disabled");
  AST_BAUD_PAIR: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (io_cycle_i && !io_d_ff && wr_i && io_baud && !baud_hi_ff) |=>
    baud_rate_factor_o[7:0] == $past(data_i))
    else $error("baud low byte lost");
  AST_TRAP_VEC: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    trap_i |=> irq_pending_o && irq_vector_o == board_glue_pkg::vec_nmi)
    else $error("trap vector wrong");
  AST_LOW_LINE: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (cfg_i.low_line_route && low_line && !rst75_i) |=> irq_vector_o == board_glue_pkg::vec_nmi)
    else $error("low line not routed");
endmodule

//--- design/board_glue_pkg.sv
// Package of constants and carriers for the board address decode and interrupt map.
// Assumes an 8-bit processor bus with 16-bit memory and 8-bit I/O addresses.
package board_glue_pkg;
  localparam logic [7:0] baud_rate_factor_offset = 8'hde;
  localparam logic [7:0] timer0_port = 8'hdc;
  localparam logic [7:0] timer1_port = 8'hdd;
  localparam logic [7:0] timer2_port = 8'hde;
  localparam logic [7:0] timer_ctrl_port = 8'hdf;
  localparam logic [6:0] pic_port_base = 7'h6c;
  localparam logic [15:0] baud_reset = 16'h0000;
  localparam logic [7:0] vec_nmi = 8'h24;
  localparam logic [7:0] vec_hi = 8'h3c;
  localparam logic [7:0] vec_mid = 8'h34;
  localparam logic [7:0] vec_lo = 8'h2c;
  localparam logic [15:0] rom_top_1k = 16'h0fff;
  localparam logic [15:0] rom_top_2k = 16'h1fff;
  localparam logic [15:0] rom_top_4k = 16'h3fff;
  localparam logic [15:0] rom_top_8k = 16'h7fff;
  localparam logic [1:0] ram_small_lo = 2'h3;
  localparam logic [1:0] ram_big_lo = 2'h2;
  localparam logic [1:0] rom_wait_cycles = 2'h1;
  localparam logic [1:0] pin_sync_depth = 2'h3;

  typedef enum logic [2:0] {
    rom_1k_slow,
    rom_2k_slow,
    rom_4k_slow,
    rom_4k_fast,
    rom_8k_fast
  } rom_type_e;

  typedef struct packed {
    rom_type_e rom_type;
    logic ram_expanded;
    logic [1:0] ram_segment;
    logic bank_enable;
    logic bank_rom_follow;
    logic rom_disable_allow;
    logic low_line_route;
  } config_s;

  typedef struct packed {
    logic rom;
    logic ram;
    logic baud;
    logic timer;
    logic pic;
  } select_s;
endpackage

//--- design/pin_sync.sv
// Three-stage synchroniser with an agreement filter for one outside pin.
// Assumes the pin is asynchronous to ref_clk_i.
`timescale 1ns/1ps
module pin_sync (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic pin_i,
  output logic level_o
);
  logic [2:0] stage_ff;
  logic [2:0] nxt_stage;
  logic level_ff;
  logic nxt_level;

  always_comb begin
    nxt_stage = {stage_ff[1:0], pin_i};
    nxt_level = level_ff;
    if (stage_ff[1] == stage_ff[2]) begin
      nxt_level = stage_ff[2];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      stage_ff <= 3'h0;
      level_ff <= 1'b0;
    end else begin
      stage_ff <= nxt_stage;
      level_ff <= nxt_level;
    end
  end

  assign level_o = level_ff;
endmodule

//--- testbench/cpu_bus_model.sv
// Processor bus model: opens and closes memory, I/O and bank port cycles.
// Assumes the bench calls its tasks; every change lands on a falling edge.
`timescale 1ns/1ps
module cpu_bus_model (
  input wire logic ref_clk_i,
  output logic mem_cycle_o,
  output logic io_cycle_o,
  output logic wr_o,
  output logic [15:0] addr_o,
  output logic [7:0] data_o,
  output logic bank_port_wr_o
);
  initial begin
    mem_cycle_o = 1'b0;
    io_cycle_o = 1'b0;
    wr_o = 1'b0;
    addr_o = 16'hffff;
    data_o = 8'h00;
    bank_port_wr_o = 1'b0;
  end
  // Opens a cycle; a two-byte load is two cycles to one port
  task automatic start(input logic io, input logic w, input logic [15:0] a, input logic [7:0] d);
    @(negedge ref_clk_i);
    mem_cycle_o <= !io;
    io_cycle_o <= io;
    wr_o <= w;
    addr_o <= a;
    data_o <= d;
  endtask
  // Closes a cycle; strobes drop low, address and data show the inverse of their last value
  task automatic stop;
    @(negedge ref_clk_i);
    mem_cycle_o <= 1'b0;
    io_cycle_o <= 1'b0;
    wr_o <= 1'b0;
    addr_o <= ~addr_o;
    data_o <= ~data_o;
  endtask
  // Port bit write: bit 0 bank, bit 1 onboard ROM enable
  task automatic bank_write(input logic [7:0] d);
    @(negedge ref_clk_i);
    bank_port_wr_o <= 1'b1;
    data_o <= d;
    @(negedge ref_clk_i);
    bank_port_wr_o <= 1'b0;
    data_o <= ~d;
  endtask
endmodule

//--- testbench/board_glue_bench.sv
// Bench for board_glue: decode, waits, port bits, byte steering, vectors.
// Assumes cpu_bus_model drives the bus; inputs change on the falling edge.
`timescale 1ns/1ps
module board_glue_bench;
  logic ref_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic mem_cycle, io_cycle, wr, bank_wr, offboard, ready, bank, rom_en, pic2, pending;
  logic trap, rst75, rst65, rst55, low_line;
  logic [15:0] addr, baud;
  logic [7:0] data, vector;
  logic [1:0] tbyte;
  board_glue_pkg::config_s cfg;
  board_glue_pkg::select_s sel;
  int failures = 0;
  int comparisons = 0;
  always #5 ref_clk_i = ~ref_clk_i;
  board_glue dut_u (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .cfg_i(cfg),
    .mem_cycle_i(mem_cycle), .io_cycle_i(io_cycle), .wr_i(wr), .addr_i(addr), .data_i(data),
    .trap_i(trap), .rst75_i(rst75), .rst65_i(rst65), .rst55_i(rst55),
    .supply_low_line_i(low_line), .bank_port_wr_i(bank_wr), .sel_o(sel),
    .offboard_o(offboard), .ready_o(ready), .bank_o(bank), .onboard_rom_enable_o(rom_en),
    .baud_rate_factor_o(baud), .timer_byte_o(tbyte), .pic_second_reg_o(pic2),
    .irq_pending_o(pending), .irq_vector_o(vector));
  cpu_bus_model bus_u (.ref_clk_i(ref_clk_i), .mem_cycle_o(mem_cycle),
    .io_cycle_o(io_cycle), .wr_o(wr), .addr_o(addr), .data_o(data), .bank_port_wr_o(bank_wr));
  task automatic close_out;
    if (failures == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick;
    @(negedge ref_clk_i);
  endtask
  // Memory cycle: selects and wait state in the first cycle, ready high in the second
  task automatic mem_chk(input logic [15:0] a, input logic r, input logic m, input logic rdy);
    bus_u.start(1'b0, 1'b0, a, 8'h00);
    tick();
    chk(sel.rom, r);
    chk(sel.ram, m);
    chk({sel.baud, sel.timer, sel.pic}, 16'h0);
    chk(offboard, !(r | m));
    chk(ready, rdy);
    bus_u.stop();
    chk(ready, 1'b1);
  endtask
  task automatic io_wr(input logic [7:0] port, input logic [7:0] d);
    bus_u.start(1'b1, 1'b1, {8'h00, port}, d);
    tick();
    bus_u.stop();
  endtask
  task automatic tm_wr(input logic [7:0] port, input logic [1:0] exp);
    bus_u.start(1'b1, 1'b1, {8'h00, port}, 8'h5a);
    tick();
    chk(tbyte, exp);
    chk(sel.timer, 1'b1);
    bus_u.stop();
  endtask
  task automatic t_rom;
    for (int i = 0; i < 5; i++) begin
      cfg.rom_type = board_glue_pkg::rom_type_e'(i);
      mem_chk(16'h0000, 1'b1, 1'b0, i > 2);
    end
    cfg.rom_type = board_glue_pkg::rom_1k_slow;
    mem_chk(16'h0fff, 1'b1, 1'b0, 1'b0);
    mem_chk(16'h1000, 1'b0, 1'b0, 1'b1);
    cfg.rom_type = board_glue_pkg::rom_2k_slow;
    mem_chk(16'h1fff, 1'b1, 1'b0, 1'b0);
    mem_chk(16'h2000, 1'b0, 1'b0, 1'b1);
  endtask
  task automatic t_ram;
    mem_chk(16'h3000, 1'b0, 1'b1, 1'b1);
    mem_chk(16'h2fff, 1'b0, 1'b0, 1'b1);
    cfg.ram_expanded = 1'b1;
    mem_chk(16'h2000, 1'b0, 1'b1, 1'b1);
    cfg.ram_expanded = 1'b0;
    cfg.ram_segment = 2'h1;
    mem_chk(16'h7fff, 1'b0, 1'b1, 1'b1);
    mem_chk(16'h3000, 1'b0, 1'b0, 1'b1);
    cfg.ram_segment = 2'h3;
    mem_chk(16'hf000, 1'b0, 1'b1, 1'b1);
    cfg.ram_segment = 2'h0;
  endtask
  task automatic t_io;
    io_wr(board_glue_pkg::baud_rate_factor_offset, 8'h12);
    chk({sel.baud, sel.timer}, 16'h2);
    chk(baud[7:0], 8'h12);
    io_wr(board_glue_pkg::baud_rate_factor_offset, 8'h34);
    chk(baud, 16'h3412);
    tm_wr(board_glue_pkg::timer_ctrl_port, 2'b00);
    tm_wr(board_glue_pkg::timer0_port, 2'b01);
    tm_wr(board_glue_pkg::timer0_port, 2'b11);
    tm_wr(board_glue_pkg::timer1_port, 2'b01);
    tm_wr(board_glue_pkg::timer_ctrl_port, 2'b00);
    tm_wr(board_glue_pkg::timer1_port, 2'b01);
    io_wr({board_glue_pkg::pic_port_base, 1'b0}, 8'h00);
    chk({sel.pic, pic2}, 16'h2);
    io_wr({board_glue_pkg::pic_port_base, 1'b0}, 8'h10);
    chk(pic2, 1'b1);
    io_wr({board_glue_pkg::pic_port_base, 1'b1}, 8'hff);
    chk({sel.pic, pic2}, 16'h2);
  endtask
  task automatic t_bank;
    cfg.rom_type = board_glue_pkg::rom_8k_fast;
    cfg.bank_enable = 1'b1;
    cfg.bank_rom_follow = 1'b1;
    cfg.rom_disable_allow = 1'b1;
    bus_u.bank_write(8'h03);
    chk({bank, rom_en}, 16'h3);
    mem_chk(16'h0000, 1'b0, 1'b0, 1'b1);
    bus_u.bank_write(8'h00);
    chk({bank, rom_en}, 16'h0);
    mem_chk(16'h0000, 1'b0, 1'b0, 1'b1);
    cfg.rom_disable_allow = 1'b0;
    mem_chk(16'h0000, 1'b1, 1'b0, 1'b1);
  endtask
  task automatic t_irq;
    logic [3:0] pat [6] = '{4'h8, 4'h4, 4'h2, 4'h1, 4'h7, 4'h3};
    logic [7:0] vec [6] = '{8'h24, 8'h3c, 8'h34, 8'h2c, 8'h3c, 8'h34};
    for (int i = 0; i < 6; i++) begin
      {trap, rst75, rst65, rst55} = pat[i];
      tick();
      chk({pending, vector}, {1'b1, vec[i]});
      {trap, rst75, rst65, rst55} = 4'h0;
      tick();
      chk(pending, 1'b0);
    end
    low_line = 1'b1;
    repeat (8) tick();
    chk(pending, 1'b0);
    cfg.low_line_route = 1'b1;
    for (int i = 0; i < 8 && vector !== 8'h24; i++) begin
      tick();
    end
    chk({pending, vector}, 16'h124);
  endtask
  initial begin
    #200000;
    failures++;
    close_out();
  end
  initial begin
    cfg = '0;
    {trap, rst75, rst65, rst55, low_line} = 5'h00;
    repeat (3) tick();
    reset_i = 1'b0;
    chk({sel, offboard, ready, bank, rom_en, pending}, 16'h00a);
    chk(baud, board_glue_pkg::baud_reset);
    chk(vector, 8'h00);
    t_rom();
    t_ram();
    t_io();
    t_bank();
    t_irq();
    close_out();
  end
endmodule
